// File: include/pwmsd_pkg.sv
// Purpose: constants for the pwm stage with fault shutdown
// Assumes: 100 MHz clock, avalon-mm word registers
// Notes: offsets are byte addresses
package pwmsd_pkg;
    localparam logic [3:0] ADDR_SHUTDOWN = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_DUTY = 4'h8;
    localparam logic [3:0] ADDR_TIMER = 4'hC;
    localparam int SD_FLAG_BIT = 7;
    localparam int SRC_MSB = 6;
    localparam int SRC_LSB = 4;
    localparam int PAIR1_MSB = 3;
    localparam int PAIR1_LSB = 2;
    localparam int PAIR2_MSB = 1;
    localparam int PAIR2_LSB = 0;
    // timer control bits
    localparam int TMR_RUN_BIT = 0;
    localparam int TMR_PS_LSB = 1;
    localparam int TMR_FLAG_BIT = 3;
    localparam int TMR_RESTART_BIT = 4;
    localparam int TMR_COMPARATOR_TWO_SYNC_ENABLE_BIT = 5;
    localparam int TMR_DIR_BIT = 6;
    localparam int TMR_MODE_BIT = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_DIR = 8'h40;
    localparam logic [3:0] C2_DELAY_CYCLES = 4'h4;
endpackage

// File: rtl/pwmsd_prescaler.sv
// Purpose: period timer tick divider
// Assumes: single clock, sleep freezes the count
// Notes: 00 /1, 01 /4, 1x /16
`timescale 1ns/1ps
`default_nettype none
module pwmsd_prescaler (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_run,
    input wire logic [1:0] i_sel,
    // tick
    output logic o_tick
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_tick;
    logic [3:0] lim;
    always_comb begin
        lim = (i_sel == 2'h0) ? 4'h0 : ((i_sel == 2'h1) ? 4'h3 : 4'hF);
        next_cnt = cnt;
        next_tick = 1'b0;
        if (i_run) begin
            if (cnt >= lim) begin
                next_cnt = 4'h0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 4'h0;
            o_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// File: rtl/pwmsd_top.sv
// Functional notes
// - sleep stops the period timer and freezes its count and the pin state; register writes and fault flags still act
// - driven pins hold their level while asleep
// - after wake the timer continues from its held count
// - pwm timing derives only from the system clock
// - any reset sets pins to input and registers to reset values
// - each pair drives 00 low, 01 high, 1x tri-state
// - shutdown is level based and lasts while the fault lasts
// - status bit writes are ignored while the fault is present
// - restarted outputs resume only at the next period start
// - with auto restart the status bit clears when fault ends
//
// Purpose: pwm output stage with auto shutdown, avalon-mm slave
// Assumes: fault pins asynchronous, pass three flops
// Notes: waitrequest low for one cycle per access
`timescale 1ns/1ps
`default_nettype none
module pwmsd_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // avalon-mm slave
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // power and fault inputs
    input wire logic i_sleep,
    input wire logic i_comparator_one,
    input wire logic i_comparator_two,
    input wire logic i_int_pin,
    // bridge outputs a,b,c,d
    output logic [3:0] o_bridge_out,
    output logic [3:0] o_bridge_oe
);
    ////////////////////////////////////////////////////////////////////
    logic [2:0] c1_s, c2_s, int_s;
    logic [7:0] sd_ctrl, period, duty, tctl, tcount;
    logic [1:0] duty_lo;
    logic [3:0] c2_dly;
    logic active, wreq_q;
    logic [3:0] out_q, oe_q;
    logic ack;
    logic [7:0] next_sd_ctrl, next_period, next_duty, next_tctl, next_tcount;
    logic [1:0] next_duty_lo;
    logic [3:0] next_c2_dly, next_out, next_oe;
    logic next_active, next_ack;
    logic [31:0] next_rd, rd_q;
    logic tick, c2_eff, fault, wr_sel, ovf;
    logic [2:0] src;

    // fault inputs come from other domains
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            c1_s <= 3'h0;
            c2_s <= 3'h0;
            int_s <= 3'h7;
        end else begin
            c1_s <= {c1_s[1:0], i_comparator_one};
            c2_s <= {c2_s[1:0], i_comparator_two};
            int_s <= {int_s[1:0], i_int_pin};
        end
    end

    // prescaler gated by sleep so the count freezes in place
    pwmsd_prescaler u_pre (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_run(tctl[pwmsd_pkg::TMR_RUN_BIT] & ~i_sleep),
        .i_sel(tctl[pwmsd_pkg::TMR_PS_LSB +: 2]),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        src = sd_ctrl[pwmsd_pkg::SRC_MSB:pwmsd_pkg::SRC_LSB];
        c2_eff = tctl[pwmsd_pkg::TMR_COMPARATOR_TWO_SYNC_ENABLE_BIT] ?
            (c2_dly == pwmsd_pkg::C2_DELAY_CYCLES) : c2_s[2];
        fault = (src[0] & c1_s[2]) | (src[1] & c2_eff) |
            (src[2] & ~int_s[2]);
        // a tick launched just before sleep must not move the count
        ovf = tick & ~i_sleep & (tcount >= period);
        // write lands at the edge that ends the wait, not before
        wr_sel = i_write & ack;
        next_sd_ctrl = sd_ctrl;
        next_period = period;
        next_duty = duty;
        next_duty_lo = duty_lo;
        next_tctl = tctl;
        next_tcount = tcount;
        next_c2_dly = c2_s[2] ? ((c2_dly == pwmsd_pkg::C2_DELAY_CYCLES) ?
            c2_dly : c2_dly + 4'h1) : 4'h0;
        next_ack = (i_read | i_write) & ~ack;
        next_rd = rd_q;
        if (wr_sel) begin
            case (i_address)
                pwmsd_pkg::ADDR_SHUTDOWN: begin
                    next_sd_ctrl[6:0] = i_writedata[6:0];
                    if (!fault) begin
                        next_sd_ctrl[pwmsd_pkg::SD_FLAG_BIT] = i_writedata[7];
                    end
                end
                pwmsd_pkg::ADDR_PERIOD: next_period = i_writedata[7:0];
                pwmsd_pkg::ADDR_DUTY: begin
                    next_duty = i_writedata[7:0];
                    next_duty_lo = i_writedata[9:8];
                end
                pwmsd_pkg::ADDR_TIMER: next_tctl = i_writedata[7:0];
                default: begin
                end
            endcase
        end
        if (tick && !i_sleep) begin
            next_tcount = ovf ? 8'h00 : tcount + 8'h01;
        end
        // hardware set wins over software clear
        if (ovf) begin
            next_tctl[pwmsd_pkg::TMR_FLAG_BIT] = 1'b1;
        end
        if (fault) begin
            next_sd_ctrl[pwmsd_pkg::SD_FLAG_BIT] = 1'b1;
        end else if (sd_ctrl[pwmsd_pkg::SD_FLAG_BIT] &&
            tctl[pwmsd_pkg::TMR_RESTART_BIT]) begin
            next_sd_ctrl[pwmsd_pkg::SD_FLAG_BIT] = 1'b0;
        end
        if (i_read && !ack) begin
            case (i_address)
                pwmsd_pkg::ADDR_SHUTDOWN: next_rd = {24'h0, sd_ctrl};
                pwmsd_pkg::ADDR_PERIOD: next_rd = {24'h0, period};
                pwmsd_pkg::ADDR_DUTY: next_rd = {22'h0, duty_lo, duty};
                pwmsd_pkg::ADDR_TIMER: next_rd = {16'h0, tcount, tctl};
                default: next_rd = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_active = active;
        next_out = out_q;
        next_oe = oe_q;
        if (sd_ctrl[pwmsd_pkg::SD_FLAG_BIT]) begin
            next_active = 1'b0;
        end else if (!active && ovf) begin
            next_active = 1'b1;
        end
        if (active && !sd_ctrl[pwmsd_pkg::SD_FLAG_BIT]) begin
            next_out = {4{({tcount, 2'h0} < {duty, duty_lo})}};
            next_out[1] = ~next_out[0];
            next_out[3] = ~next_out[2];
            next_oe = tctl[pwmsd_pkg::TMR_MODE_BIT] &
                ~tctl[pwmsd_pkg::TMR_DIR_BIT] ? 4'hF : 4'h0;
        end else if (sd_ctrl[pwmsd_pkg::SD_FLAG_BIT]) begin
            // a,c on pair one; b,d on pair two
            next_out[0] = sd_ctrl[pwmsd_pkg::PAIR1_LSB];
            next_out[2] = sd_ctrl[pwmsd_pkg::PAIR1_LSB];
            next_out[1] = sd_ctrl[pwmsd_pkg::PAIR2_LSB];
            next_out[3] = sd_ctrl[pwmsd_pkg::PAIR2_LSB];
            next_oe[0] = ~sd_ctrl[pwmsd_pkg::PAIR1_MSB];
            next_oe[2] = ~sd_ctrl[pwmsd_pkg::PAIR1_MSB];
            next_oe[1] = ~sd_ctrl[pwmsd_pkg::PAIR2_MSB];
            next_oe[3] = ~sd_ctrl[pwmsd_pkg::PAIR2_MSB];
        end
        if (i_sleep) begin
            next_active = active;
            next_out = out_q;
            next_oe = oe_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sd_ctrl <= pwmsd_pkg::RESET_BYTE;
            period <= pwmsd_pkg::RESET_BYTE;
            duty <= pwmsd_pkg::RESET_BYTE;
            duty_lo <= 2'h0;
            tctl <= pwmsd_pkg::RESET_DIR;
            tcount <= pwmsd_pkg::RESET_BYTE;
            c2_dly <= 4'h0;
            active <= 1'b0;
            wreq_q <= 1'b1;
            out_q <= 4'h0;
            oe_q <= 4'h0;
            ack <= 1'b0;
            rd_q <= 32'h0;
        end else begin
            sd_ctrl <= next_sd_ctrl;
            period <= next_period;
            duty <= next_duty;
            duty_lo <= next_duty_lo;
            tctl <= next_tctl;
            tcount <= next_tcount;
            c2_dly <= next_c2_dly;
            active <= next_active;
            wreq_q <= ~next_ack;
            out_q <= next_out;
            oe_q <= next_oe;
            ack <= next_ack;
            rd_q <= next_rd;
        end
    end

    assign o_bridge_out = out_q;
    assign o_bridge_oe = oe_q;
    assign o_readdata = rd_q;
    assign o_waitrequest = wreq_q;

    ////////////////////////////////////////////////////////////////////
    sequence s_fault_then_flag;
        fault ##1 sd_ctrl[7];
    endsequence
    AST_FAULT_FLAG: assert property (@(posedge i_clk) disable iff (!i_reset_n) fault |-> s_fault_then_flag) else $error("fault did not set flag");
    AST_FLAG_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n) fault |=> sd_ctrl[7]) else $error("flag cleared under fault");
    AST_SD_OE: assert property (@(posedge i_clk) disable iff (!i_reset_n) (sd_ctrl[7] && $stable(sd_ctrl) && !i_sleep) |=> (oe_q[0] == !$past(sd_ctrl[3]))) else $error("pair one enable wrong");
    AST_SD_LVL: assert property (@(posedge i_clk) disable iff (!i_reset_n) (sd_ctrl[7] && $stable(sd_ctrl) && !i_sleep) |=> (out_q[1] == $past(sd_ctrl[0]))) else $error("pair two level wrong");
    AST_SLEEP_TMR: assert property (@(posedge i_clk) disable iff (!i_reset_n) i_sleep |=> $stable(tcount)) else $error("timer moved in sleep");
    AST_SLEEP_PIN: assert property (@(posedge i_clk) disable iff (!i_reset_n) i_sleep |=> $stable(out_q) && $stable(oe_q)) else $error("pin changed in sleep");
    AST_RESUME: assert property (@(posedge i_clk) disable iff (!i_reset_n) (!active && !ovf) |=> !active) else $error("resumed mid period");
    AST_AUTO_CLR: assert property (@(posedge i_clk) disable iff (!i_reset_n) (!fault && sd_ctrl[7] && tctl[4] && !wr_sel) |=> !sd_ctrl[7]) else $error("auto restart failed");
    AST_NO_SRC: assert property (@(posedge i_clk) disable iff (!i_reset_n) (src == 3'h0) |-> !fault) else $error("fault with source off");
endmodule
`default_nettype wire

// File: test/pwmsd_fault_model.sv
// Purpose: far side model, comparators and fault pin
// Assumes: bench asks for fault levels
// Notes: levels change just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pwmsd_fault_model (
    // clock
    input wire logic i_clk,
    // fault requests from the bench
    input wire logic i_c1,
    input wire logic i_c2,
    input wire logic i_pin,
    // to the device
    output logic o_comparator_one,
    output logic o_comparator_two,
    output logic o_int_pin
);
    always_ff @(posedge i_clk) begin
        o_comparator_one <= i_c1;
        o_comparator_two <= i_c2;
        // pin fault is a low level, pulled high otherwise
        o_int_pin <= !i_pin;
    end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: register level tests of the pwm fault shutdown stage
// Assumes: avalon-mm access, two cycles per access
// Notes: fault latency is covered by fixed waits
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_address = 4'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic i_sleep = 1'b0;
    logic c1 = 1'b0, c2 = 1'b0, pf = 1'b0;
    wire logic comp1, comp2, int_pin;
    wire logic [31:0] o_readdata;
    wire logic o_waitrequest;
    wire logic [3:0] o_bridge_out, o_bridge_oe;
    logic [31:0] rdv;
    logic [3:0] held;
    int miscompares = 0, checks = 0, cycles = 0, n;
    always #5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////
    pwmsd_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_sleep(i_sleep),
        .i_comparator_one(comp1), .i_comparator_two(comp2),
        .i_int_pin(int_pin), .o_bridge_out(o_bridge_out),
        .o_bridge_oe(o_bridge_oe));
    pwmsd_fault_model far (.i_clk(i_clk), .i_c1(c1), .i_c2(c2),
        .i_pin(pf), .o_comparator_one(comp1),
        .o_comparator_two(comp2), .o_int_pin(int_pin));
    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        // whole run needs a few hundred cycles
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic [3:0] a, input logic wr_n_rd,
            input logic [31:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr_n_rd;
        i_read <= !wr_n_rd;
        // hold until waitrequest is seen low at an edge
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        rdv = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a,
            input logic [31:0] m, input logic [31:0] exp);
        acc(a, 1'b0, 32'h0);
        chk(nm, rdv & m, exp);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(20);
        i_reset_n <= 1'b1;
        chk("oe_reset", o_bridge_oe, 32'h0);
        rd_chk("sd_reset", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'h0);
        rd_chk("tmr_reset", pwmsd_pkg::ADDR_TIMER, 32'hFF, 32'h40);
        rd_chk("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
        acc(pwmsd_pkg::ADDR_TIMER, 1'b1, 32'h40);
        acc(pwmsd_pkg::ADDR_PERIOD, 1'b1, 32'h8);
        acc(pwmsd_pkg::ADDR_TIMER, 1'b1, 32'hC0);
        acc(pwmsd_pkg::ADDR_DUTY, 1'b1, 32'h4);
        acc(pwmsd_pkg::ADDR_TIMER, 1'b1, 32'hC1);
        n = 0;
        // wait for the overflow flag before driving the pins
        do begin
            acc(pwmsd_pkg::ADDR_TIMER, 1'b0, 32'h0);
            n = n + 1;
        end while (rdv[3] !== 1'b1 && n < 50);
        chk("ovf_flag", rdv[3], 32'h1);
        acc(pwmsd_pkg::ADDR_TIMER, 1'b1, 32'h81);
        wait_cyc(40);
        chk("oe_run", o_bridge_oe, 32'hF);
        i_sleep <= 1'b1;
        wait_cyc(2);
        held = o_bridge_out;
        acc(pwmsd_pkg::ADDR_TIMER, 1'b0, 32'h0);
        n = rdv[15:8];
        wait_cyc(30);
        chk("sleep_hold", o_bridge_out, held);
        chk("sleep_oe", o_bridge_oe, 32'hF);
        rd_chk("sleep_cnt", pwmsd_pkg::ADDR_TIMER, 32'hFF00, n << 8);
        i_sleep <= 1'b0;
        rd_chk("wake_cnt", pwmsd_pkg::ADDR_TIMER, 32'hFF00, n << 8);
        // source comparator one, both pairs high: never a running pattern
        acc(pwmsd_pkg::ADDR_SHUTDOWN, 1'b1, 32'h15);
        c1 <= 1'b1;
        wait_cyc(8);
        rd_chk("sd_set", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'h95);
        chk("sd_out", o_bridge_out, 32'hF);
        chk("sd_oe", o_bridge_oe, 32'hF);
        acc(pwmsd_pkg::ADDR_SHUTDOWN, 1'b1, 32'h15);
        rd_chk("sd_wr_ign", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'h95);
        c1 <= 1'b0;
        wait_cyc(8);
        rd_chk("sd_stays", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'h95);
        acc(pwmsd_pkg::ADDR_SHUTDOWN, 1'b1, 32'h15);
        rd_chk("sd_clr", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'h15);
        // source pin low, both pairs tri-state, auto restart on
        acc(pwmsd_pkg::ADDR_TIMER, 1'b1, 32'h91);
        acc(pwmsd_pkg::ADDR_SHUTDOWN, 1'b1, 32'h4A);
        pf <= 1'b1;
        wait_cyc(8);
        chk("tri_oe", o_bridge_oe, 32'h0);
        rd_chk("pin_set", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'hCA);
        pf <= 1'b0;
        wait_cyc(8);
        rd_chk("auto_clr", pwmsd_pkg::ADDR_SHUTDOWN, 32'hFF, 32'h4A);
        wait_cyc(40);
        chk("resume_oe", o_bridge_oe, 32'hF);
        // comparator two through the sync delay, both pairs tri-state
        acc(pwmsd_pkg::ADDR_TIMER, 1'b1, 32'hB1);
        acc(pwmsd_pkg::ADDR_SHUTDOWN, 1'b1, 32'h2A);
        c2 <= 1'b1;
        wait_cyc(7);
        chk("c2_delay", o_bridge_oe, 32'hF);
        wait_cyc(5);
        chk("c2_shut", o_bridge_oe, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
